//--- logic/regulator_dvs_map.svh
`ifndef REGULATOR_DVS_MAP_SVH
`define REGULATOR_DVS_MAP_SVH
// Summary of operation
// - Pin enable selections count only with sequencing field 111 and enable field 10.
// - With several pins selected, the regulator enable is the OR of all selected pin levels.
// - Selection bit n set makes control pin n an enable source, and clear leaves it out.
// - Code 0 disables scaling, 1..28 pick pairs 0/1..6/7 in order, 29 serial, rest reserved.
// - With a pin pair selected (codes 1..28) and the pins at 00, the first alternate voltage code is applied.
// - A code maps linearly to voltage: code 0 is 0.55 V and each increment adds one step.
// - Pins at 01, 10 or 11 apply the second, third or fourth alternate voltage code.
`define ADDR_PIN_ENABLE_SELECT 8'h2c
`define ADDR_PAIR_SELECT 8'h2d
`define ADDR_ALT_VOLTAGE_0 8'h2e
`define ADDR_ALT_VOLTAGE_1 8'h2f
`define ADDR_ALT_VOLTAGE_2 8'h30
`define ADDR_ALT_VOLTAGE_3 8'h31
`define RST_PIN_ENABLE_SELECT 8'h00
`define RST_PAIR_CODE 5'h00
`define RST_ALT_VOLTAGE 6'h00
`define PAIR_CODE_W 5
`define VCODE_W 6
`define SEQ_PIN_MODE 3'h7
`define EN_PIN_MODE 2'h2
`define PAIR_CODE_OFF 5'h00
`define PAIR_CODE_LAST 5'h1c
`define PAIR_CODE_SERIAL 5'h1d
`define NUM_PINS 8
`define BASE_VOLTAGE_MV 12'h0226
`define STEP_10_MV 12'h000a
`define STEP_25_MV 12'h0019
`define STEP_50_MV 12'h0032
`define STEP_SEL_10 2'h0
`define STEP_SEL_25 2'h1
`endif

//--- logic/regulator_dvs_pkg.sv
package regulator_dvs_pkg;
    typedef enum logic [1:0] {
        dvs_off,
        dvs_pins,
        dvs_serial,
        dvs_reserved
    } dvs_mode_t;
endpackage : regulator_dvs_pkg

//--- logic/pair_code_decoder.sv
`timescale 1ns/10ps
`include "regulator_dvs_map.svh"
module pair_code_decoder (
    input wire logic [4:0] pair_code,
    output regulator_dvs_pkg::dvs_mode_t mode,
    output logic [2:0] low_pin,
    output logic [2:0] high_pin
);
    // pairs enumerated in ascending order, code 1 = pins 0/1
    always_comb begin
        logic [4:0] idx;
        idx = 5'h01;
        low_pin = 3'h0;
        high_pin = 3'h0;
        for (int i = 0; i < `NUM_PINS; i++) begin
            for (int j = i + 1; j < `NUM_PINS; j++) begin
                if (idx == pair_code) begin
                    low_pin = 3'(i);
                    high_pin = 3'(j);
                end
                idx = idx + 5'h01;
            end
        end
        if (pair_code == `PAIR_CODE_OFF) begin
            mode = regulator_dvs_pkg::dvs_off;
        end else if (pair_code <= `PAIR_CODE_LAST) begin
            mode = regulator_dvs_pkg::dvs_pins;
        end else if (pair_code == `PAIR_CODE_SERIAL) begin
            mode = regulator_dvs_pkg::dvs_serial;
        end else begin
            mode = regulator_dvs_pkg::dvs_reserved;
        end
    end
endmodule : pair_code_decoder

//--- logic/regulator_pin_enable_dvs_select.sv
`timescale 1ns/10ps
`include "regulator_dvs_map.svh"
module regulator_pin_enable_dvs_select (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] multipurpose_pin,
    input wire logic [2:0] regulator_sequencing_field,
    input wire logic [1:0] regulator_enable_field,
    input wire logic [1:0] voltage_step_size,
    input wire logic [5:0] nominal_voltage_code,
    input wire logic [5:0] serial_voltage_code,
    output logic pin_mode_active,
    output logic pin_enable_request,
    output logic dvs_active,
    output logic dvs_serial_mode,
    output logic [1:0] dvs_selector,
    output logic [5:0] applied_voltage_code,
    output logic [11:0] applied_voltage_mv
);
    logic [7:0] pin_enable_select;
    logic [4:0] scaling_pair_code;
    logic [5:0] alt_voltage_code [4];
    regulator_dvs_pkg::dvs_mode_t mode;
    logic [2:0] low_pin;
    logic [2:0] high_pin;
    logic pin_mode;
    logic [1:0] next_selector;
    logic [5:0] next_code;
    logic [11:0] step_mv;
    logic write_pin_enable_select;
    logic write_pair_select;
    logic [3:0] write_alt_voltage;
    logic [7:0] pin_source;
    logic next_active;
    logic next_serial;
    logic [11:0] next_mv;

    // unmapped offsets and unused upper bits read as zero
    function automatic logic [7:0] read_mux(input logic [7:0] addr,
                                            input logic [7:0] pes,
                                            input logic [4:0] pc,
                                            input logic [5:0] a0,
                                            input logic [5:0] a1,
                                            input logic [5:0] a2,
                                            input logic [5:0] a3);
        unique case (addr)
            `ADDR_PIN_ENABLE_SELECT: read_mux = pes;
            `ADDR_PAIR_SELECT: read_mux = {3'h0, pc};
            `ADDR_ALT_VOLTAGE_0: read_mux = {2'h0, a0};
            `ADDR_ALT_VOLTAGE_1: read_mux = {2'h0, a1};
            `ADDR_ALT_VOLTAGE_2: read_mux = {2'h0, a2};
            `ADDR_ALT_VOLTAGE_3: read_mux = {2'h0, a3};
            default: read_mux = 8'h00;
        endcase
    endfunction : read_mux

    // one address compare shared by every write strobe
    function automatic logic write_hit(input logic strobe, input logic [7:0] addr,
                                       input logic [7:0] target);
        write_hit = strobe && (addr == target);
    endfunction : write_hit

    // step sizes 2 and 3 both give the coarse step
    function automatic logic [11:0] step_of(input logic [1:0] size);
        unique case (size)
            `STEP_SEL_10: step_of = `STEP_10_MV;
            `STEP_SEL_25: step_of = `STEP_25_MV;
            default: step_of = `STEP_50_MV;
        endcase
    endfunction : step_of

    // write strobes, one per register
    assign write_pin_enable_select = write_hit(reg_write, reg_addr, `ADDR_PIN_ENABLE_SELECT);
    assign write_pair_select = write_hit(reg_write, reg_addr, `ADDR_PAIR_SELECT);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_enable_select <= `RST_PIN_ENABLE_SELECT;
        end else if (write_pin_enable_select) begin
            pin_enable_select <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scaling_pair_code <= `RST_PAIR_CODE;
        end else if (write_pair_select) begin
            scaling_pair_code <= reg_wdata[4:0];
        end
    end

    // four alternate codes, each with its own write strobe
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_alt
            assign write_alt_voltage[g] = write_hit(reg_write, reg_addr,
                                                    `ADDR_ALT_VOLTAGE_0 + 8'(g));
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    alt_voltage_code[g] <= `RST_ALT_VOLTAGE;
                end else if (write_alt_voltage[g]) begin
                    alt_voltage_code[g] <= reg_wdata[5:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            // read data holds until the next read strobe
            reg_rdata <= read_mux(reg_addr, pin_enable_select, scaling_pair_code,
                                  alt_voltage_code[0], alt_voltage_code[1],
                                  alt_voltage_code[2], alt_voltage_code[3]);
        end
    end

    // selections only honoured in pin-sequenced enable mode
    assign pin_mode = (regulator_sequencing_field == `SEQ_PIN_MODE)
                   && (regulator_enable_field == `EN_PIN_MODE);

    // each selection bit gates its own pin
    genvar p;
    generate
        for (p = 0; p < `NUM_PINS; p++) begin : g_pin_gate
            assign pin_source[p] = pin_enable_select[p] && multipurpose_pin[p];
        end
    endgenerate

    // mode flag registered like every other output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_mode_active <= 1'b0;
        end else begin
            pin_mode_active <= pin_mode;
        end
    end

    // any gated pin raises the enable, nothing does outside pin mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_enable_request <= 1'b0;
        end else begin
            pin_enable_request <= pin_mode && (|pin_source);
        end
    end

    // pair decode is a pure table, kept in its own module
    pair_code_decoder i_pair_code_decoder (
        .pair_code(scaling_pair_code),
        .mode(mode),
        .low_pin(low_pin),
        .high_pin(high_pin)
    );

    always_comb begin
        next_selector = {multipurpose_pin[high_pin], multipurpose_pin[low_pin]};
        next_active = (mode == regulator_dvs_pkg::dvs_pins)
                   || (mode == regulator_dvs_pkg::dvs_serial);
        next_serial = (mode == regulator_dvs_pkg::dvs_serial);
        unique case (mode)
            regulator_dvs_pkg::dvs_pins: begin
                next_code = alt_voltage_code[next_selector];
            end
            regulator_dvs_pkg::dvs_serial: next_code = serial_voltage_code;
            default: next_code = nominal_voltage_code;
        endcase
        step_mv = step_of(voltage_step_size);
        // at most 3700 mV, so twelve bits never overflow
        next_mv = 12'(`BASE_VOLTAGE_MV + 12'(next_code) * step_mv);
    end

    // every output below follows its inputs one edge later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dvs_active <= 1'b0;
        end else begin
            dvs_active <= next_active;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dvs_serial_mode <= 1'b0;
        end else begin
            dvs_serial_mode <= next_serial;
        end
    end

    // selector only shows pin levels in pin-pair mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dvs_selector <= 2'h0;
        end else begin
            dvs_selector <= (next_active && !next_serial) ? next_selector : 2'h0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            applied_voltage_code <= `RST_ALT_VOLTAGE;
        end else begin
            applied_voltage_code <= next_code;
        end
    end

    // millivolt view of the applied code
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            applied_voltage_mv <= `BASE_VOLTAGE_MV;
        end else begin
            applied_voltage_mv <= next_mv;
        end
    end
endmodule : regulator_pin_enable_dvs_select

//--- tb/pin_host_model.sv
`timescale 1ns/10ps
module pin_host_model (
    input wire logic clk,
    input wire logic [7:0] want,
    output logic [7:0] multipurpose_pin
);
    initial multipurpose_pin = 8'h00;
    // host moves its pins just after each rising edge
    always @(posedge clk) multipurpose_pin <= #1 want;
endmodule : pin_host_model

//--- tb/regulator_pin_enable_dvs_select_sva.sv
`timescale 1ns/10ps
module regulator_dvs_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] multipurpose_pin,
    input wire logic [2:0] regulator_sequencing_field,
    input wire logic pin_mode_active,
    input wire logic pin_enable_request,
    input wire logic dvs_active,
    input wire logic dvs_serial_mode,
    input wire logic [1:0] dvs_selector
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_SEQ: assert property (regulator_sequencing_field != 3'h7 |=> !pin_mode_active)
        else $error("pin mode outside sequencing");
    AST_ROSE: assert property ($rose(pin_mode_active) |->
        $past(regulator_sequencing_field) == 3'h7) else $error("pin mode rose wrongly");
    AST_REQ: assert property (!pin_mode_active |-> !pin_enable_request)
        else $error("enable outside pin mode");
    AST_NOPIN: assert property (multipurpose_pin == 8'h00 |=> !pin_enable_request)
        else $error("enable with all pins low");
    AST_SER: assert property (dvs_serial_mode |-> dvs_active && dvs_selector == 2'h0)
        else $error("serial mode state");
    AST_IDLE: assert property (!dvs_active |-> dvs_selector == 2'h0)
        else $error("selector while idle");
    AST_LOW: assert property (multipurpose_pin == 8'h00 |=> dvs_selector == 2'h0)
        else $error("selector with pins low");
    AST_HIGH: assert property (multipurpose_pin == 8'hff |=>
        !dvs_active || dvs_serial_mode || dvs_selector == 2'h3) else $error("selector high");
endmodule : regulator_dvs_sva
bind regulator_pin_enable_dvs_select regulator_dvs_sva i_regulator_dvs_sva (
    .clk(clk),
    .rst_n(rst_n),
    .multipurpose_pin(multipurpose_pin),
    .regulator_sequencing_field(regulator_sequencing_field),
    .pin_mode_active(pin_mode_active),
    .pin_enable_request(pin_enable_request),
    .dvs_active(dvs_active),
    .dvs_serial_mode(dvs_serial_mode),
    .dvs_selector(dvs_selector)
);

//--- tb/tb_regulator_pin_enable_dvs_select.sv
`timescale 1ns/10ps
module tb_regulator_pin_enable_dvs_select;
    logic clk = 1'h0, rst_n = 1'h0, reg_write = 1'h0, reg_read = 1'h0, pin_mode_active;
    logic pin_enable_request, dvs_active, dvs_serial_mode;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, want = 8'h00, sel, reg_rdata, multipurpose_pin;
    logic [2:0] seq = 3'h0;
    logic [1:0] en = 2'h0, step = 2'h0, dvs_selector;
    logic [5:0] nom = 6'h00, ser = 6'h00, ex, applied_voltage_code, alt [4];
    logic [11:0] applied_voltage_mv;
    int mismatches = 0, comparisons = 0, seed = 32'h0000_900c, lo, hi;
    pin_host_model i_pin_host_model (.clk, .want, .multipurpose_pin);
    regulator_pin_enable_dvs_select i_regulator_pin_enable_dvs_select (.clk, .rst_n, .reg_addr,
        .reg_wdata, .reg_write, .reg_read, .reg_rdata, .multipurpose_pin,
        .regulator_sequencing_field(seq), .regulator_enable_field(en), .voltage_step_size(step),
        .nominal_voltage_code(nom), .serial_voltage_code(ser), .pin_mode_active,
        .pin_enable_request, .dvs_active, .dvs_serial_mode, .dvs_selector,
        .applied_voltage_code, .applied_voltage_mv);
    always #50 clk = ~clk;
    task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1 {reg_write, reg_read, reg_addr, reg_wdata} = {w, !w, a, d};
        @(posedge clk) #1 {reg_write, reg_read} = 2'h0;
        if (!w) chk("rdata", reg_rdata, d);
    endtask : acc
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    function automatic logic [11:0] mv(input logic [5:0] c, input logic [1:0] s);
        return 12'h0226 + c * (s == 2'h0 ? 12'h000a : s == 2'h1 ? 12'h0019 : 12'h0032);
    endfunction : mv
    initial begin
        #1_000_000;
        mismatches++;
        summarize;
    end
    initial begin
        #351 rst_n = 1'h1;
        chk("reset mv", applied_voltage_mv, 12'h0226);
        // reset values, 0x32 unmapped
        for (int a = 8'h2c; a < 8'h33; a++) acc(1'h0, a[7:0], 8'h00);
        for (int i = 0; i < 4; i++) begin
            alt[i] = 6'($random(seed));
            acc(1'h1, 8'h2e + i[7:0], {2'h3, alt[i]});
            acc(1'h0, 8'h2e + i[7:0], {2'h0, alt[i]});
        end
        for (int i = 0; i < 60; i++) begin
            sel = i < 8 ? 8'h01 << i : 8'($random(seed));
            acc(1'h1, 8'h2c, sel);
            {seq, en} = i % 3 ? 5'h1e : 5'($random(seed));
            want = i == 8 ? 8'h00 : i == 9 ? 8'hff : 8'($random(seed));
            repeat (3) @(posedge clk) #1;
            chk("mode", pin_mode_active, {seq, en} == 5'h1e);
            chk("enable", pin_enable_request,
                {seq, en} == 5'h1e && |(sel & want));
        end
        seq = 3'h0;
        lo = 0;
        hi = 0;
        for (int c = 0; c < 32; c++) begin
            acc(1'h1, 8'h2d, c[7:0]);
            lo = hi == 7 ? lo + 1 : lo;
            hi = hi == 7 ? lo + 1 : hi + (c > 0);
            for (int v = 0; v < 4; v++) begin
                {step, nom, ser, want} = 22'($random(seed));
                want = v == 0 && c[0] ? 8'h00 : v == 3 && c[0] ? 8'hff : want;
                want[lo[2:0]] = v[0];
                want[hi[2:0]] = v[1];
                ex = c == 29 ? ser : c > 0 && c < 29 ? alt[v] : nom;
                repeat (3) @(posedge clk) #1;
                chk("active", dvs_active, c > 0 && c < 30);
                chk("serial", dvs_serial_mode, c == 29);
                chk("selector", dvs_selector, 12'(c > 0 && c < 29 ? v : 0));
                chk("code", applied_voltage_code, ex);
                chk("mv", applied_voltage_mv, mv(ex, step));
            end
        end
        summarize;
    end
endmodule : tb_regulator_pin_enable_dvs_select
